// ### design/cpu_clock_mode_select_consts.svh
`ifndef CPU_CLOCK_MODE_SELECT_CONSTS_SVH
`define CPU_CLOCK_MODE_SELECT_CONSTS_SVH

// ****************************************
// Strap codes for the clock mode pins
// ****************************************
`define STRAP_W 3
`define STRAP_X4 3'h7
`define STRAP_X3 3'h6
`define STRAP_X8 3'h5
`define STRAP_X5 3'h4
`define STRAP_DIRECT 3'h3
`define STRAP_X10 3'h2
`define STRAP_PRESCALE 3'h1
`define STRAP_X16 3'h0
`define STRAP_RESET_VALUE 3'h7

// ****************************************
// Multiplier encodings (0 means not multiplied)
// ****************************************
`define MULT_W 5
`define MULT_NONE 5'h00
`define MULT_1 5'h01
`define MULT_3 5'h03
`define MULT_4 5'h04
`define MULT_5 5'h05
`define MULT_8 5'h08
`define MULT_10 5'h0A
`define MULT_16 5'h10

// ****************************************
// Oscillator watchdog
// ****************************************
`define OWD_DISABLE_BIT 4
`define OWD_CNT_W 4
`define OWD_OVERFLOW_COUNT 16
`define OWD_CNT_LAST 4'hF

`endif

// ### design/cpu_clock_mode_select_pkg.sv
`default_nettype none
`include "cpu_clock_mode_select_consts.svh"

package cpu_clock_mode_select_pkg;

  // Gray codes along PLL -> prescaler -> direct
  typedef enum logic [1:0] {
    MODE_PLL = 2'h0,
    MODE_PRESCALE = 2'h1,
    MODE_DIRECT = 2'h3
  } clk_mode_t;

  typedef struct packed {
    clk_mode_t mode;
    logic [`MULT_W-1:0] mult;
    logic pll_on;
    logic amp_bypass;
    logic failover;
  } clk_status_t;

endpackage : cpu_clock_mode_select_pkg

`default_nettype wire

// ### design/cpu_clock_mode_select.sv
// Operation
// RQ1: The clock mode is taken from the three strap bits while the device reset is held.
// RQ2: Strap 111 gives x4 (default), 110 x3, 101 x8, 100 x5, 010 x10 and 000 x16 through the PLL.
// RQ3: Strap 001 makes the CPU clock the input clock halved by a 2:1 prescaler.
// RQ4: In prescaler mode each high and each low phase lasts exactly one input clock period.
// RQ5: Strap 011 turns the PLL off, bypasses the oscillator amplifier and uses the crystal pin directly; the code keeps the PLL on with the watchdog enabled.
// RQ6: In direct drive the CPU clock follows the input, so two consecutive phases make one input period.
// RQ7: In prescaler or direct mode with the watchdog enabled the PLL free-runs and clocks the watchdog.
// RQ8: In prescaler or direct mode with the watchdog disabled the PLL is switched off.
// RQ9: Both CPU clock edges are reported so that pipeline and bus actions may use either.
// RQ10: The oscillator watchdog is enabled after reset and disabled by configuration bit 4.
// RQ11: The watchdog counter counts PLL ticks, clears on each input edge, and on 16 counts fails over and flags.
// RQ12: After a failover the CPU clock stays on the PLL until the next device reset.
// RQ13: The strap code is held from the end of reset until the next reset.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_clock_mode_select_consts.svh"

module cpu_clock_mode_select (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sys_reset_n,
  input wire logic [`STRAP_W-1:0] clock_mode_strap_pins,
  input wire logic crystal_input_pin,
  input wire logic pll_tick,
  input wire logic osc_watchdog_disable,
  output logic cpu_clock_phase,
  output logic cpu_rise,
  output logic cpu_fall,
  output logic owd_irq,
  output var cpu_clock_mode_select_pkg::clk_status_t status
);
  import cpu_clock_mode_select_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [`STRAP_W-1:0] clock_mode_strap_bits_reg;
  logic xtal_reg;
  logic [`OWD_CNT_W-1:0] owd_cnt_reg;
  logic failover_reg;
  logic cpu_clk_reg;
  logic cpu_clk_next;
  logic rise_reg;
  logic fall_reg;
  logic irq_reg;
  clk_status_t status_reg;
  clk_status_t status_next;
  clk_mode_t mode;
  logic bypass_mode;
  logic owd_armed;
  logic xtal_edge;
  logic xtal_rise;
  logic owd_overflow;

  // Strap decode to mode and multiplier
  function automatic clk_mode_t strap_mode(input logic [`STRAP_W-1:0] s);
    unique case (s)
      `STRAP_DIRECT: strap_mode = MODE_DIRECT;
      `STRAP_PRESCALE: strap_mode = MODE_PRESCALE;
      default: strap_mode = MODE_PLL;
    endcase
  endfunction : strap_mode

  function automatic logic [`MULT_W-1:0] strap_mult(input logic [`STRAP_W-1:0] s);
    unique case (s)
      `STRAP_X4: strap_mult = `MULT_4;
      `STRAP_X3: strap_mult = `MULT_3;
      `STRAP_X8: strap_mult = `MULT_8;
      `STRAP_X5: strap_mult = `MULT_5;
      `STRAP_DIRECT: strap_mult = `MULT_1;
      `STRAP_X10: strap_mult = `MULT_10;
      `STRAP_PRESCALE: strap_mult = `MULT_NONE;
      `STRAP_X16: strap_mult = `MULT_16;
    endcase
  endfunction : strap_mult

  // ****************************************
  // Strap capture
  // ****************************************
  // Sampled on every rising clk edge while the device reset is low, frozen once it lifts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_mode_strap_bits_reg <= `STRAP_RESET_VALUE;
    end else if (!sys_reset_n) begin
      clock_mode_strap_bits_reg <= clock_mode_strap_pins; // [RQ1] [RQ13]
    end
  end

  // Input clock edge detection; the pin is taken as synchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xtal_reg <= 1'b0;
    end else begin
      xtal_reg <= crystal_input_pin;
    end
  end

  assign mode = strap_mode(clock_mode_strap_bits_reg);
  assign bypass_mode = (mode != MODE_PLL);
  assign owd_armed = bypass_mode && !osc_watchdog_disable && !failover_reg; // [RQ10]
  assign xtal_edge = crystal_input_pin != xtal_reg;
  assign xtal_rise = crystal_input_pin && !xtal_reg;
  assign owd_overflow = owd_armed && pll_tick && !xtal_edge && (owd_cnt_reg == `OWD_CNT_LAST);

  // ****************************************
  // Oscillator watchdog
  // ****************************************
  // Input edge wins over a tick: a live crystal must never be counted out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      owd_cnt_reg <= '0;
    end else if (!owd_armed || xtal_edge || !sys_reset_n) begin
      owd_cnt_reg <= '0; // [RQ11]
    end else if (pll_tick) begin
      owd_cnt_reg <= owd_cnt_reg + 1'b1; // [RQ11]
    end
  end

  // Failover is sticky; only the device reset brings back the input clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      failover_reg <= 1'b0;
    end else if (!sys_reset_n) begin
      failover_reg <= 1'b0; // [RQ12]
    end else if (owd_overflow) begin
      failover_reg <= 1'b1; // [RQ11] [RQ12]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= owd_overflow && sys_reset_n; // [RQ11]
    end
  end

  // ****************************************
  // CPU clock generation
  // ****************************************
  always_comb begin
    cpu_clk_next = cpu_clk_reg;
    if (failover_reg) begin
      cpu_clk_next = pll_tick ? !cpu_clk_reg : cpu_clk_reg; // [RQ11]
    end else begin
      unique case (mode)
        MODE_PLL: cpu_clk_next = pll_tick ? !cpu_clk_reg : cpu_clk_reg; // [RQ2]
        MODE_PRESCALE: cpu_clk_next = xtal_rise ? !cpu_clk_reg : cpu_clk_reg; // [RQ3] [RQ4]
        MODE_DIRECT: cpu_clk_next = crystal_input_pin; // [RQ5] [RQ6]
      endcase
    end
  end

  // Edge strobes line up with the clock level they announce
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      cpu_clk_reg <= cpu_clk_next;
      rise_reg <= cpu_clk_next && !cpu_clk_reg; // [RQ9]
      fall_reg <= !cpu_clk_next && cpu_clk_reg; // [RQ9]
    end
  end

  // ****************************************
  // Status
  // ****************************************
  always_comb begin
    status_next.mode = mode;
    status_next.mult = strap_mult(clock_mode_strap_bits_reg); // [RQ2]
    status_next.pll_on = !bypass_mode || failover_reg || !osc_watchdog_disable; // [RQ7] [RQ8]
    status_next.amp_bypass = (mode == MODE_DIRECT); // [RQ5]
    status_next.failover = failover_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '{mode: MODE_PLL, mult: `MULT_4, pll_on: 1'b1, amp_bypass: 1'b0, failover: 1'b0};
    end else begin
      status_reg <= status_next;
    end
  end

  assign cpu_clock_phase = cpu_clk_reg;
  assign cpu_rise = rise_reg;
  assign cpu_fall = fall_reg;
  assign owd_irq = irq_reg;
  assign status = status_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_running;
    sys_reset_n ##1 sys_reset_n;
  endsequence

  sequence s_last_tick;
    owd_armed && pll_tick && !xtal_edge && owd_cnt_reg == `OWD_CNT_LAST && sys_reset_n;
  endsequence

  a_strap_frozen: assert property (s_running |-> $stable(clock_mode_strap_bits_reg)) // [RQ13]
    else $error("strap code changed outside reset");
  a_strap_sampled: assert property (!sys_reset_n // [RQ1]
      |=> clock_mode_strap_bits_reg == $past(clock_mode_strap_pins))
    else $error("strap not sampled during reset");
  a_mult_x16: assert property (clock_mode_strap_bits_reg == `STRAP_X16 |=> status.mult == `MULT_16) // [RQ2]
    else $error("x16 multiplier not reported");
  a_presc_toggle: assert property (mode == MODE_PRESCALE && !failover_reg && xtal_rise // [RQ3]
      |=> cpu_clock_phase != $past(cpu_clock_phase))
    else $error("prescaler clock missed an input rise");
  a_presc_hold: assert property (mode == MODE_PRESCALE && !failover_reg && !xtal_rise // [RQ4]
      |=> $stable(cpu_clock_phase))
    else $error("prescaler phase ended early");
  a_direct_track: assert property (mode == MODE_DIRECT && !failover_reg // [RQ6]
      |=> cpu_clock_phase == $past(crystal_input_pin))
    else $error("direct drive clock not following input");
  a_direct_bypass: assert property (mode == MODE_DIRECT ##1 mode == MODE_DIRECT |-> status.amp_bypass) // [RQ5]
    else $error("amplifier not bypassed in direct drive");
  a_pll_freerun: assert property (bypass_mode && !osc_watchdog_disable |=> status.pll_on) // [RQ7]
    else $error("pll not running for the watchdog");
  a_pll_off: assert property (bypass_mode && osc_watchdog_disable && !failover_reg |=> !status.pll_on) // [RQ8] [RQ10]
    else $error("pll left on with watchdog disabled");
  a_edge_report: assert property ($rose(cpu_clock_phase) |-> cpu_rise ##1 !cpu_rise) // [RQ9]
    else $error("rising edge strobe wrong");
  a_wd_overflow: assert property (s_last_tick |=> failover_reg && owd_irq ##1 !owd_irq) // [RQ11]
    else $error("watchdog overflow not handled");
  a_no_return: assert property (failover_reg && sys_reset_n |=> failover_reg) // [RQ12]
    else $error("left failover without reset");

endmodule : cpu_clock_mode_select

`default_nettype wire

// ### bench/crystal_source_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// External crystal or clock source
// ****************************************
module crystal_source_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] high_cycles,
  input wire logic [7:0] low_cycles,
  output logic pin
);
  logic [7:0] count_reg;
  initial begin
    pin = 1'b0;
    count_reg = 8'h00;
  end
  // Free duty cycle; a stopped source holds its level like a dead oscillator
  always @(posedge clk) begin
    if (run) begin
      if (count_reg + 8'h01 >= (pin ? high_cycles : low_cycles)) begin
        pin <= ~pin;
        count_reg <= 8'h00;
      end else begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end
endmodule : crystal_source_model

`default_nettype wire

// ### bench/test_cpu_clock_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_clock_mode_select_consts.svh"

// ****************************************
// Stimulus, measurement and verdict
// ****************************************
module test_cpu_clock_mode_select;
  import cpu_clock_mode_select_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sys_reset_n = 1'b0;
  logic [2:0] straps = 3'h7;
  logic pll_tick = 1'b0;
  logic owd_dis = 1'b0;
  logic xtal_run = 1'b1;
  logic [7:0] xhi = 8'h03;
  logic [7:0] xlo = 8'h03;
  logic [7:0] tick_gap = 8'h00;
  logic [7:0] tick_cnt = 8'h00;
  logic pin, phase, rise, fall, irq;
  clk_status_t status;
  int fails = 0;
  int checked = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  crystal_source_model crystal_source_model_inst (.clk(clk), .run(xtal_run), .high_cycles(xhi),
    .low_cycles(xlo), .pin(pin));
  cpu_clock_mode_select cpu_clock_mode_select_inst (.clk(clk), .arst_n(arst_n), .sys_reset_n(sys_reset_n),
    .clock_mode_strap_pins(straps), .crystal_input_pin(pin), .pll_tick(pll_tick),
    .osc_watchdog_disable(owd_dis), .cpu_clock_phase(phase), .cpu_rise(rise), .cpu_fall(fall),
    .owd_irq(irq), .status(status));

  // Free-running PLL half-period ticks, one every tick_gap cycles
  always @(posedge clk) begin
    pll_tick <= (tick_gap != 8'h00) && (tick_cnt == tick_gap - 8'h01);
    tick_cnt <= (tick_cnt + 8'h01 >= tick_gap) ? 8'h00 : tick_cnt + 8'h01;
  end

  // Hang guard, generous over the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic strap_reset(input logic [2:0] code);
    @(posedge clk);
    sys_reset_n <= 1'b0;
    straps <= code;
    repeat (3) @(posedge clk);
    sys_reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : strap_reset

  // Cycles high after a rise, and rise-to-rise period
  task automatic measure(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    while (rise !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
    do begin @(posedge clk); #1; hi++; end while (fall !== 1'b1 && hi < 100);
    per = hi;
    do begin @(posedge clk); #1; per++; end while (rise !== 1'b1 && per < 200);
  endtask : measure

  // Every strap code, with the watchdog both enabled and disabled
  task automatic test_strap_table();
    logic [2:0] c;
    clk_mode_t m;
    logic [4:0] x;
    logic [15:0] e;
    for (int i = 0; i < 16; i++) begin
      c = i[2:0];
      @(posedge clk);
      owd_dis <= i[3];
      strap_reset(c);
      m = (c == `STRAP_PRESCALE) ? MODE_PRESCALE : (c == `STRAP_DIRECT) ? MODE_DIRECT : MODE_PLL;
      case (c)
        `STRAP_X4: x = `MULT_4;
        `STRAP_X3: x = `MULT_3;
        `STRAP_X8: x = `MULT_8;
        `STRAP_X5: x = `MULT_5;
        `STRAP_DIRECT: x = `MULT_1;
        `STRAP_X10: x = `MULT_10;
        `STRAP_PRESCALE: x = `MULT_NONE;
        default: x = `MULT_16;
      endcase
      e = {6'h00, m, x, (m == MODE_PLL) || !i[3], c == `STRAP_DIRECT, 1'b0};
      check(16'(status), e);
    end
    // Last code latched was 111; pins moved outside reset must not matter
    @(posedge clk);
    owd_dis <= 1'b0;
    straps <= `STRAP_DIRECT;
    repeat (4) @(posedge clk);
    #1;
    check(16'(status.mult), 16'(`MULT_4));
    check(16'(status.amp_bypass), 16'h0000);
  endtask : test_strap_table

  // Phase lengths in PLL, prescaler and direct drive
  task automatic test_waveforms();
    int hi;
    int per;
    tick_gap <= 8'h05;
    strap_reset(`STRAP_X4);
    measure(hi, per);
    check(16'(per), 16'h000A);
    check(16'(phase), 16'h0001);
    xhi <= 8'h02;
    xlo <= 8'h04;
    strap_reset(`STRAP_PRESCALE);
    measure(hi, per);
    check(16'(hi), 16'h0006);
    check(16'(per), 16'h000C);
    strap_reset(`STRAP_DIRECT);
    measure(hi, per);
    check(16'(hi), 16'h0002);
    check(16'(per), 16'h0006);
  endtask : test_waveforms

  // Crystal failure, sticky failover, and the disabled watchdog
  task automatic test_watchdog();
    int n;
    int hi;
    int per;
    tick_gap <= 8'h02;
    strap_reset(`STRAP_PRESCALE);
    xtal_run <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 60) begin @(posedge clk); #1; n++; end
    check(16'(n >= 28 && n <= 36), 16'h0001);
    xtal_run <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(16'(status.failover), 16'h0001);
    measure(hi, per);
    check(16'(per), 16'h0004);
    strap_reset(`STRAP_PRESCALE);
    check(16'(status.failover), 16'h0000);
    @(posedge clk);
    owd_dis <= 1'b1;
    strap_reset(`STRAP_DIRECT);
    xtal_run <= 1'b0;
    n = 0;
    repeat (60) begin @(posedge clk); #1; n += (irq === 1'b1); end
    check(16'(n), 16'h0000);
    check(16'(status.failover), 16'h0000);
    xtal_run <= 1'b1;
  endtask : test_watchdog

  initial begin
    repeat (3) @(posedge clk);
    #1;
    check(16'(status), {6'h00, MODE_PLL, `MULT_4, 3'b100});
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    test_strap_table();
    test_waveforms();
    test_watchdog();
    print_verdict();
  end
endmodule : test_cpu_clock_mode_select

`default_nettype wire
